//--- hdl/cmsbd_decoder.sv
`timescale 1ns/1ns
module cmsbd_decoder (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       opcode_valid_i,
    input  wire logic [7:0] opcode_i,
    input  wire logic       flag_sign_i,
    input  wire logic       flag_zero_i,
    input  wire logic       flag_parity_i,
    input  wire logic       flag_carry_i,
    output logic            opcode_ready_o,
    output cmsbd_pkg::cmsbd_op_t op_class_o,
    output logic [2:0]      dst_sel_o,
    output logic [2:0]      src_sel_o,
    output logic [1:0]      pair_sel_o,
    output logic            acc_flags_o,
    output logic            taken_o,
    output logic            mem_read_o,
    output logic            mem_write_o,
    output logic            unsupported_o,
    output logic [4:0]      states_o,
    output logic            busy_o,
    output logic            done_o,
    output logic [4:0]      state_o
);

    logic [7:0] op;
    logic       accept;
    logic [1:0] grp;
    logic [2:0] fld_hi;
    logic [2:0] fld_lo;
    logic       is_copy_grp;
    logic       is_copy_st;
    logic       is_copy_ld;
    logic       is_copy;
    logic       is_imm_byte;
    logic       is_imm_pair;
    logic       is_acc_grp;
    logic       is_push;
    logic       is_pop;
    logic       is_jcc;
    logic       is_ccc;
    logic       flag_pick;
    logic       cond_true;
    logic       rr_is_top;
    cmsbd_pkg::cmsbd_op_t next_class;
    logic [4:0] next_len;
    logic [1:0] next_pair;
    logic       next_taken;
    logic       next_rd;
    logic       next_wr;

    assign op             = opcode_i;
    assign grp            = op[7:6];
    assign fld_hi         = op[5:3];
    assign fld_lo         = op[2:0];
    // one opcode at a time: a new byte waits until the last state has run
    assign opcode_ready_o = !busy_o || done_o;
    assign accept         = opcode_valid_i && opcode_ready_o;
    assign rr_is_top      = op[5:4] == cmsbd_pkg::PAIR_SP_AF;

    // halt sits inside the copy pattern but is not a copy
    assign is_copy_grp = grp == 2'b01 && op != cmsbd_pkg::OP_HALT;
    assign is_copy_st  = is_copy_grp && fld_hi == cmsbd_pkg::REG_MEM;
    assign is_copy_ld  = is_copy_grp && fld_lo == cmsbd_pkg::REG_MEM
                         && !is_copy_st;
    assign is_copy     = is_copy_grp && !is_copy_st && !is_copy_ld;
    assign is_imm_byte = grp == 2'b00 && fld_lo == 3'b110;
    assign is_imm_pair = grp == 2'b00 && op[3:0] == 4'h1;
    assign is_acc_grp  = grp == 2'b00 && fld_lo == 3'b010;
    assign is_push     = grp == 2'b11 && op[3:0] == 4'h5;
    assign is_pop      = grp == 2'b11 && op[3:0] == 4'h1;
    assign is_jcc      = grp == 2'b11 && fld_lo == 3'b010;
    assign is_ccc      = grp == 2'b11 && fld_lo == 3'b100;

    // condition field: pairs of tests on zero, carry, parity, sign
    assign flag_pick = fld_hi[2:1] == 2'b00 ? flag_zero_i
                     : fld_hi[2:1] == 2'b01 ? flag_carry_i
                     : fld_hi[2:1] == 2'b10 ? flag_parity_i
                     : flag_sign_i;
    assign cond_true = flag_pick == fld_hi[0];

    always_comb begin
        next_class = cmsbd_pkg::CL_NONE;
        next_len   = cmsbd_pkg::LEN_NONE;
        next_pair  = 2'b00;
        next_taken = 1'b0;
        next_rd    = 1'b0;
        next_wr    = 1'b0;
        if (is_copy) begin
            next_class = cmsbd_pkg::CL_COPY;
            next_len   = cmsbd_pkg::LEN_COPY;
        end else if (is_copy_st) begin
            next_class = cmsbd_pkg::CL_COPY_STORE;
            next_len   = cmsbd_pkg::LEN_COPY_MEM;
            next_pair  = cmsbd_pkg::PAIR_HL;
            next_wr    = 1'b1;
        end else if (is_copy_ld) begin
            next_class = cmsbd_pkg::CL_COPY_LOAD;
            next_len   = cmsbd_pkg::LEN_COPY_MEM;
            next_pair  = cmsbd_pkg::PAIR_HL;
            next_rd    = 1'b1;
        end else if (is_imm_byte && fld_hi == cmsbd_pkg::REG_MEM) begin
            next_class = cmsbd_pkg::CL_IMM_MEM;
            next_len   = cmsbd_pkg::LEN_IMM_MEM;
            next_pair  = cmsbd_pkg::PAIR_HL;
            next_wr    = 1'b1;
        end else if (is_imm_byte) begin
            next_class = cmsbd_pkg::CL_IMM_BYTE;
            next_len   = cmsbd_pkg::LEN_IMM_BYTE;
        end else if (is_imm_pair) begin
            next_class = cmsbd_pkg::CL_IMM_PAIR;
            next_len   = cmsbd_pkg::LEN_IMM_PAIR;
            next_pair  = op[5:4];
        end else if (is_acc_grp && !op[5]) begin
            next_class = op[3] ? cmsbd_pkg::CL_IND_LOAD
                               : cmsbd_pkg::CL_IND_STORE;
            next_len   = cmsbd_pkg::LEN_IND;
            next_pair  = {1'b0, op[4]};
            next_rd    = op[3];
            next_wr    = !op[3];
        end else if (is_acc_grp && op[4]) begin
            next_class = op[3] ? cmsbd_pkg::CL_DIR_A_LOAD
                               : cmsbd_pkg::CL_DIR_A_STORE;
            next_len   = cmsbd_pkg::LEN_DIR_A;
            next_rd    = op[3];
            next_wr    = !op[3];
        end else if (is_acc_grp) begin
            next_class = op[3] ? cmsbd_pkg::CL_DIR_P_LOAD
                               : cmsbd_pkg::CL_DIR_P_STORE;
            next_len   = cmsbd_pkg::LEN_DIR_P;
            next_pair  = cmsbd_pkg::PAIR_HL;
            next_rd    = op[3];
            next_wr    = !op[3];
        end else if (op == cmsbd_pkg::OP_SWAP_PAIRS) begin
            // register-only exchange, nothing goes over the data bus
            next_class = cmsbd_pkg::CL_SWAP_PAIRS;
            next_len   = cmsbd_pkg::LEN_SWAP_PAIRS;
            next_pair  = cmsbd_pkg::PAIR_DE;
        end else if (is_push) begin
            next_class = cmsbd_pkg::CL_PUSH;
            next_len   = cmsbd_pkg::LEN_PUSH;
            next_pair  = op[5:4];
            next_wr    = 1'b1;
        end else if (is_pop) begin
            next_class = cmsbd_pkg::CL_POP;
            next_len   = cmsbd_pkg::LEN_POP;
            next_pair  = op[5:4];
            next_rd    = 1'b1;
        end else if (op == cmsbd_pkg::OP_SWAP_STACK) begin
            next_class = cmsbd_pkg::CL_SWAP_STACK;
            next_len   = cmsbd_pkg::LEN_SWAP_STACK;
            next_pair  = cmsbd_pkg::PAIR_HL;
            next_rd    = 1'b1;
            next_wr    = 1'b1;
        end else if (op == cmsbd_pkg::OP_PAIR_TO_SP) begin
            next_class = cmsbd_pkg::CL_PAIR_TO_SP;
            next_len   = cmsbd_pkg::LEN_PAIR_MOVE;
            next_pair  = cmsbd_pkg::PAIR_HL;
        end else if (op == cmsbd_pkg::OP_PAIR_TO_PC) begin
            next_class = cmsbd_pkg::CL_PAIR_TO_PC;
            next_len   = cmsbd_pkg::LEN_PAIR_MOVE;
            next_pair  = cmsbd_pkg::PAIR_HL;
            next_taken = 1'b1;
        end else if (op == cmsbd_pkg::OP_BRANCH || is_jcc) begin
            next_class = cmsbd_pkg::CL_BRANCH;
            next_taken = op == cmsbd_pkg::OP_BRANCH || cond_true;
            next_len   = next_taken ? cmsbd_pkg::LEN_BRANCH
                                    : cmsbd_pkg::LEN_BRANCH_NOT;
        end else if (op == cmsbd_pkg::OP_CALL || is_ccc) begin
            next_class = cmsbd_pkg::CL_CALL;
            next_taken = op == cmsbd_pkg::OP_CALL || cond_true;
            next_len   = next_taken ? cmsbd_pkg::LEN_CALL
                                    : cmsbd_pkg::LEN_CALL_NOT;
            next_wr    = next_taken;
        end else begin
            next_class = cmsbd_pkg::CL_NONE;
        end
    end

    // decoded fields held for the whole instruction
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_class_o    <= cmsbd_pkg::CL_NONE;
            dst_sel_o     <= 3'h0;
            src_sel_o     <= 3'h0;
            pair_sel_o    <= 2'h0;
            acc_flags_o   <= 1'b0;
            taken_o       <= 1'b0;
            mem_read_o    <= 1'b0;
            mem_write_o   <= 1'b0;
            unsupported_o <= 1'b0;
            states_o      <= 5'h00;
        end else if (accept) begin
            op_class_o    <= next_class;
            dst_sel_o     <= fld_hi;
            src_sel_o     <= fld_lo;
            pair_sel_o    <= next_pair;
            acc_flags_o   <= (is_push || is_pop) && rr_is_top;
            taken_o       <= next_taken;
            mem_read_o    <= next_rd;
            mem_write_o   <= next_wr;
            unsupported_o <= next_class == cmsbd_pkg::CL_NONE;
            states_o      <= next_len;
        end
    end

    cmsbd_state_seq u_seq (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .start_i (accept),
        .len_i   (next_len),
        .busy_o  (busy_o),
        .done_o  (done_o),
        .state_o (state_o)
    );

    default clocking dec_cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    copy_len_a: assert property (
        accept && is_copy |=> op_class_o == cmsbd_pkg::CL_COPY
        && states_o == 5'h04 && dst_sel_o == $past(op[5:3]))
        else $error("register copy decoded wrongly");
    copy_store_a: assert property (
        accept && op[7:3] == 5'b01110 && op[2:0] != 3'b110
        |=> mem_write_o && states_o == 5'h07)
        else $error("store to memory decoded wrongly");
    copy_load_a: assert property (
        accept && op[7:6] == 2'b01 && op[5:3] != 3'b110 && op[2:0] == 3'b110
        |=> mem_read_o && states_o == 5'h07)
        else $error("load from memory decoded wrongly");
    imm_pair_a: assert property (
        accept && op[7:6] == 2'b00 && op[3:0] == 4'h1
        |=> states_o == 5'h0a && pair_sel_o == $past(op[5:4]))
        else $error("immediate pair load decoded wrongly");
    swap_pairs_a: assert property (
        accept && op == 8'heb |=> states_o == 5'h04
        && !mem_read_o && !mem_write_o ##3 done_o)
        else $error("pair swap decoded wrongly");
    push_pair_a: assert property (
        accept && op[7:6] == 2'b11 && op[3:0] == 4'h5 && op[5:4] != 2'b11
        |=> states_o == 5'h0c && !acc_flags_o)
        else $error("pair push decoded wrongly");
    push_flags_a: assert property (
        accept && op == 8'hf5 |=> states_o == 5'h0c && acc_flags_o)
        else $error("accumulator push decoded wrongly");
    pop_pair_a: assert property (
        accept && op[7:6] == 2'b11 && op[3:0] == 4'h1 && op[5:4] != 2'b11
        |=> states_o == 5'h0a && mem_read_o && !acc_flags_o)
        else $error("pair pop decoded wrongly");
    pop_flags_a: assert property (
        accept && op == 8'hf1 |=> states_o == 5'h0a && acc_flags_o)
        else $error("accumulator pop decoded wrongly");
    stack_swap_a: assert property (
        accept && op == 8'he3 |=> states_o == 5'h10 ##15 done_o)
        else $error("stack top swap decoded wrongly");
    sp_load_a: assert property (
        accept && op == 8'hf9 |=> op_class_o == cmsbd_pkg::CL_PAIR_TO_SP
        && states_o == 5'h06)
        else $error("stack pointer load decoded wrongly");
    pc_load_a: assert property (
        accept && op == 8'he9 |=> op_class_o == cmsbd_pkg::CL_PAIR_TO_PC
        && states_o == 5'h06)
        else $error("program counter load decoded wrongly");
    jump_len_a: assert property (
        accept && op[7:6] == 2'b11 && op[2:0] == 3'b010
        |=> states_o == (taken_o ? 5'h0a : 5'h07)
        && taken_o == $past(cond_true))
        else $error("conditional jump length wrong");
    imm_byte_a: assert property (
        accept && op[7:6] == 2'b00 && op[2:0] == 3'b110
        |=> states_o == ($past(op[5:3]) == 3'b110 ? 5'h0a : 5'h07))
        else $error("immediate byte load decoded wrongly");
    call_len_a: assert property (
        accept && (op == 8'hcd || op[7:6] == 2'b11 && op[2:0] == 3'b100)
        |=> states_o == (taken_o ? 5'h12 : 5'h09))
        else $error("call length wrong");
    acc_direct_a: assert property (
        accept && op[7:6] == 2'b00 && op[2:0] == 3'b010
        |=> states_o == ($past(op[5:4]) == 2'b11 ? 5'h0d
                       : $past(op[5]) ? 5'h10 : 5'h07))
        else $error("accumulator or pair transfer length wrong");

    taken_jump_c: cover property (accept && is_jcc && cond_true);
    untaken_call_c: cover property (accept && is_ccc && !cond_true);
    back_to_back_c: cover property (done_o && accept);

endmodule

//--- hdl/cmsbd_pkg.sv
package cmsbd_pkg;

    // operation classes reported for each accepted opcode byte
    typedef enum logic [4:0] {
        CL_NONE        = 5'b00000,
        CL_COPY        = 5'b00001,
        CL_COPY_STORE  = 5'b00010,
        CL_COPY_LOAD   = 5'b00011,
        CL_IMM_BYTE    = 5'b00100,
        CL_IMM_MEM     = 5'b00101,
        CL_IMM_PAIR    = 5'b00110,
        CL_IND_STORE   = 5'b00111,
        CL_IND_LOAD    = 5'b01000,
        CL_DIR_A_STORE = 5'b01001,
        CL_DIR_A_LOAD  = 5'b01010,
        CL_DIR_P_STORE = 5'b01011,
        CL_DIR_P_LOAD  = 5'b01100,
        CL_SWAP_PAIRS  = 5'b01101,
        CL_PUSH        = 5'b01110,
        CL_POP         = 5'b01111,
        CL_SWAP_STACK  = 5'b10000,
        CL_PAIR_TO_SP  = 5'b10001,
        CL_PAIR_TO_PC  = 5'b10010,
        CL_BRANCH      = 5'b10011,
        CL_CALL        = 5'b10100
    } cmsbd_op_t;

    // fixed opcode bytes
    localparam logic [7:0] OP_SWAP_PAIRS  = 8'heb;
    localparam logic [7:0] OP_SWAP_STACK  = 8'he3;
    localparam logic [7:0] OP_PAIR_TO_SP  = 8'hf9;
    localparam logic [7:0] OP_PAIR_TO_PC  = 8'he9;
    localparam logic [7:0] OP_BRANCH      = 8'hc3;
    localparam logic [7:0] OP_CALL        = 8'hcd;
    localparam logic [7:0] OP_HALT        = 8'h76;

    // field codes
    localparam logic [2:0] REG_MEM        = 3'h6;
    localparam logic [1:0] PAIR_DE        = 2'h1;
    localparam logic [1:0] PAIR_HL        = 2'h2;
    localparam logic [1:0] PAIR_SP_AF     = 2'h3;

    // clock-state counts
    localparam logic [4:0] LEN_NONE       = 5'h01;
    localparam logic [4:0] LEN_COPY       = 5'h04;
    localparam logic [4:0] LEN_COPY_MEM   = 5'h07;
    localparam logic [4:0] LEN_IMM_BYTE   = 5'h07;
    localparam logic [4:0] LEN_IMM_MEM    = 5'h0a;
    localparam logic [4:0] LEN_IMM_PAIR   = 5'h0a;
    localparam logic [4:0] LEN_IND        = 5'h07;
    localparam logic [4:0] LEN_DIR_A      = 5'h0d;
    localparam logic [4:0] LEN_DIR_P      = 5'h10;
    localparam logic [4:0] LEN_SWAP_PAIRS = 5'h04;
    localparam logic [4:0] LEN_PUSH       = 5'h0c;
    localparam logic [4:0] LEN_POP        = 5'h0a;
    localparam logic [4:0] LEN_SWAP_STACK = 5'h10;
    localparam logic [4:0] LEN_PAIR_MOVE  = 5'h06;
    localparam logic [4:0] LEN_BRANCH     = 5'h0a;
    localparam logic [4:0] LEN_BRANCH_NOT = 5'h07;
    localparam logic [4:0] LEN_CALL       = 5'h12;
    localparam logic [4:0] LEN_CALL_NOT   = 5'h09;

endpackage

//--- hdl/cmsbd_state_seq.sv
`timescale 1ns/1ns
module cmsbd_state_seq (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       start_i,
    input  wire logic [4:0] len_i,
    output logic            busy_o,
    output logic            done_o,
    output logic [4:0]      state_o
);

    logic [4:0] remain;
    logic [4:0] next_remain;
    logic       next_busy;
    logic [4:0] next_state;

    // a start is honoured at any time, even mid-op, and restarts the count; the caller gates it with ready
    assign next_busy   = start_i ? 1'b1 : (busy_o && remain != 5'h00);
    assign next_remain = start_i ? len_i - 5'h01
                       : (busy_o ? remain - 5'h01 : 5'h00);
    assign next_state  = start_i ? 5'h01
                       : (next_busy ? state_o + 5'h01 : 5'h00);
    assign done_o      = busy_o && remain == 5'h00;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o  <= 1'b0;
            remain  <= 5'h00;
            state_o <= 5'h00;
        end else begin
            busy_o  <= next_busy;
            remain  <= next_remain;
            state_o <= next_state;
        end
    end

    default clocking seq_cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    four_states_a: assert property (
        start_i && len_i == 5'h04 |=> (busy_o && !done_o)[*3] ##1 done_o)
        else $error("four state op did not end on its fourth state");
    ten_states_a: assert property (
        start_i && len_i == 5'h0a |=> !done_o[*8] ##1 !done_o ##1 done_o)
        else $error("ten state op did not end on its tenth state");
    idle_after_a: assert property (done_o && !start_i |=> !busy_o)
        else $error("sequencer stayed busy after its last state");

endmodule

//--- verif/cmsbd_opcode_mem.sv
`timescale 1ns/1ns
// program memory feeding opcode bytes, one per accept, optional idle gap
module cmsbd_opcode_mem (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       start_i,
    input  wire logic [1:0] gap_i,
    input  wire logic       ready_i,
    output logic            valid_o,
    output logic [7:0]      byte_o
);
    logic [7:0]  prog [0:7];
    int unsigned count = 0;
    int unsigned pc;
    logic [1:0]  wait_cnt;
    logic [7:0]  last;
    logic        run;

    // offers only between a start and its last byte, so a bench that loads
    // a new program mid-cycle cannot leak a byte before the start
    assign valid_o = run && (pc < count) && (wait_cnt == 2'h0);
    // released bus shows the inverse of the last byte, not a stale copy
    assign byte_o = valid_o ? prog[pc[2:0]] : ~last;

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc <= 8;
            wait_cnt <= 2'h0;
            last <= 8'h00;
            run <= 1'b0;
        end else if (start_i) begin
            pc <= 0;
            wait_cnt <= gap_i;
            run <= 1'b1;
        end else if (valid_o && ready_i) begin
            pc <= pc + 1;
            run <= (pc + 1 < count);
            wait_cnt <= gap_i;
            last <= prog[pc[2:0]];
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule

//--- verif/cpu_move_stack_branch_decoder_tb.sv
`timescale 1ns/1ns
module cpu_move_stack_branch_decoder_tb;
    logic       clock_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic [3:0] flags = 4'h0;
    logic       start = 1'b0;
    logic [1:0] gap = 2'h0;
    logic       acc_q = 1'b0;
    wire        valid;
    wire [7:0]  opcode;
    wire        ready;
    wire        busy;
    wire        done;
    int         bad_count = 0;
    int         cmp_count = 0;
    // ex bits: check taken, taken, check rd/wr, rd, wr
    localparam logic [4:0] RW0 = 5'h04;
    localparam logic [4:0] RD = 5'h06;
    localparam logic [4:0] WR = 5'h05;
    localparam logic [4:0] NOCHK = 5'h00;

    cmsbd_opcode_mem mem (.clock_i(clock_i), .rstn_i(rstn_i), .start_i(start),
        .gap_i(gap), .ready_i(ready), .valid_o(valid), .byte_o(opcode));

    cmsbd_decoder dut (.clock_i(clock_i), .rstn_i(rstn_i),
        .opcode_valid_i(valid), .opcode_i(opcode), .flag_sign_i(flags[3]),
        .flag_zero_i(flags[2]), .flag_parity_i(flags[1]),
        .flag_carry_i(flags[0]), .opcode_ready_o(ready), .op_class_o(),
        .dst_sel_o(), .src_sel_o(), .pair_sel_o(), .acc_flags_o(),
        .taken_o(), .mem_read_o(), .mem_write_o(), .unsupported_o(),
        .states_o(), .busy_o(busy), .done_o(done), .state_o());

    initial begin
        forever #20 clock_i = ~clock_i;
    end

    always @(posedge clock_i) acc_q <= valid && ready;

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask

    function automatic logic cond(input logic [2:0] c, input logic [3:0] f);
        logic [3:0] m;
        m = {f[3], f[1], f[0], f[2]};
        return m[c[2:1]] == c[0];
    endfunction

    // leaves the caller in the first cycle after the accept edge
    task automatic run_prog(input logic [3:0] f, input logic [1:0] g);
        int n;
        @(posedge clock_i);
        flags <= f;
        gap <= g;
        @(posedge clock_i);
        start <= 1'b1;
        @(posedge clock_i);
        start <= 1'b0;
        #1;
        n = 0;
        while (acc_q !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check("accept wait", 8'(n < 20), 8'h01);
    endtask

    task automatic chk(input logic [7:0] op, input logic [3:0] f,
                       input cmsbd_pkg::cmsbd_op_t cls, input logic [4:0] len,
                       input logic [4:0] ex);
        int n;
        mem.prog[0] = op;
        mem.count = 1;
        run_prog(f, 2'h0);
        check("class", 8'(dut.op_class_o), 8'(cls));
        check("states", 8'(dut.states_o), 8'(len));
        check("unsup", 8'(dut.unsupported_o), 8'(cls == cmsbd_pkg::CL_NONE));
        if (ex[4]) check("taken", 8'(dut.taken_o), 8'(ex[3]));
        if (ex[2]) check("rd wr", 8'({dut.mem_read_o, dut.mem_write_o}),
                         8'(ex[1:0]));
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check("length", 8'(n), 8'(len));
        check("last state", 8'(dut.state_o), 8'(len));
    endtask

    task automatic t_copy();
        for (int d = 0; d < 8; d++) begin
            for (int s = 0; s < 8; s++) begin
                if (d != 6 && s != 6) begin
                    chk({2'b01, 3'(d), 3'(s)}, 4'h0, cmsbd_pkg::CL_COPY,
                        5'h04, RW0);
                    check("dst src", {2'b00, dut.dst_sel_o, dut.src_sel_o},
                          {2'b00, 3'(d), 3'(s)});
                end
            end
        end
    endtask

    task automatic t_mem_copy();
        for (int r = 0; r < 8; r++) begin
            if (r != 6) begin
                chk(8'h70 | 8'(r), 4'h0, cmsbd_pkg::CL_COPY_STORE, 5'h07, WR);
                chk(8'h46 | 8'(r << 3), 4'h0, cmsbd_pkg::CL_COPY_LOAD, 5'h07, RD);
                chk(8'h06 | 8'(r << 3), 4'h0, cmsbd_pkg::CL_IMM_BYTE, 5'h07, NOCHK);
            end
        end
        chk(8'h36, 4'h0, cmsbd_pkg::CL_IMM_MEM, 5'h0a, WR);
        chk(8'h76, 4'h0, cmsbd_pkg::CL_NONE, 5'h01, NOCHK);
    endtask

    task automatic t_pairs();
        for (int r = 0; r < 4; r++) begin
            chk(8'h01 | 8'(r << 4), 4'h0, cmsbd_pkg::CL_IMM_PAIR, 5'h0a, NOCHK);
            check("pair", 8'(dut.pair_sel_o), 8'(r));
            chk(8'hc5 | 8'(r << 4), 4'h0, cmsbd_pkg::CL_PUSH, 5'h0c, WR);
            check("push acc", 8'({dut.acc_flags_o, dut.pair_sel_o}),
                  8'({r == 3, 2'(r)}));
            chk(8'hc1 | 8'(r << 4), 4'h0, cmsbd_pkg::CL_POP, 5'h0a, RD);
            check("pop acc", 8'({dut.acc_flags_o, dut.pair_sel_o}),
                  8'({r == 3, 2'(r)}));
        end
        for (int r = 0; r < 2; r++) begin
            chk(8'h02 | 8'(r << 4), 4'h0, cmsbd_pkg::CL_IND_STORE, 5'h07, WR);
            chk(8'h0a | 8'(r << 4), 4'h0, cmsbd_pkg::CL_IND_LOAD, 5'h07, RD);
        end
        chk(8'h32, 4'h0, cmsbd_pkg::CL_DIR_A_STORE, 5'h0d, WR);
        chk(8'h3a, 4'h0, cmsbd_pkg::CL_DIR_A_LOAD, 5'h0d, RD);
        chk(8'h22, 4'h0, cmsbd_pkg::CL_DIR_P_STORE, 5'h10, WR);
        chk(8'h2a, 4'h0, cmsbd_pkg::CL_DIR_P_LOAD, 5'h10, RD);
    endtask

    task automatic t_misc();
        chk(8'heb, 4'h0, cmsbd_pkg::CL_SWAP_PAIRS, 5'h04, RW0);
        chk(8'he3, 4'h0, cmsbd_pkg::CL_SWAP_STACK, 5'h10, 5'h07);
        chk(8'hf9, 4'h0, cmsbd_pkg::CL_PAIR_TO_SP, 5'h06, RW0);
        chk(8'he9, 4'h0, cmsbd_pkg::CL_PAIR_TO_PC, 5'h06, 5'h1c);
        chk(8'hc3, 4'h0, cmsbd_pkg::CL_BRANCH, 5'h0a, 5'h1c);
        chk(8'hcd, 4'h0, cmsbd_pkg::CL_CALL, 5'h12, 5'h1d);
    endtask

    // every condition code against both flag levels
    task automatic t_cond();
        logic       t;
        logic [3:0] f;
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 2; k++) begin
                // only the tested flag follows k, so a wrong pick shows
                f = {4{k[0]}} ^ {c[2:1] != 2'b11, c[2:1] != 2'b00,
                                 c[2:1] != 2'b10, c[2:1] != 2'b01};
                t = cond(3'(c), f);
                chk(8'hc2 | 8'(c << 3), f, cmsbd_pkg::CL_BRANCH,
                    t ? 5'h0a : 5'h07, {1'b1, t, 3'b100});
                chk(8'hc4 | 8'(c << 3), f, cmsbd_pkg::CL_CALL,
                    t ? 5'h12 : 5'h09, {1'b1, t, 2'b10, t});
            end
        end
    endtask

    // offered bytes wait out a busy decoder and are each taken once
    task automatic t_b2b(input logic [1:0] g);
        int nb;
        int nd;
        int nr;
        mem.prog[0] = 8'h41;
        mem.prog[1] = 8'heb;
        mem.prog[2] = 8'h01;
        mem.prog[3] = 8'h76;
        mem.count = 4;
        run_prog(4'h0, g);
        nb = 0;
        nd = 0;
        nr = 0;
        while (busy === 1'b1 && nb < 80) begin
            nb++;
            nd += int'(done === 1'b1);
            nr += int'(ready === 1'b0);
            @(posedge clock_i);
            #1;
        end
        check("busy span", 8'(nb), 8'd19);
        check("done count", 8'(nd), 8'd4);
        check("refused", 8'(nr), 8'd15);
        check("taken bytes", 8'(mem.pc), 8'd4);
    endtask

    // a call cut short by reset leaves the decoder idle and usable
    task automatic t_reset();
        mem.prog[0] = cmsbd_pkg::OP_CALL;
        mem.count = 1;
        run_prog(4'h0, 2'h0);
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b0;
        #1;
        check("rst idle", 8'({busy, done, ready}), 8'h01);
        check("rst class", 8'(dut.op_class_o), 8'(cmsbd_pkg::CL_NONE));
        check("rst state", 8'(dut.state_o), 8'h00);
        @(posedge clock_i);
        rstn_i <= 1'b1;
        chk(8'h53, 4'h0, cmsbd_pkg::CL_COPY, 5'h04, RW0);
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_copy();
        t_mem_copy();
        t_pairs();
        t_misc();
        t_cond();
        t_b2b(2'h0);
        t_b2b(2'h2);
        t_reset();
        end_of_test();
    end

    initial begin
        #(40 * 30000);
        bad_count++;
        end_of_test();
    end
endmodule
